// ---- hdl/fopc_otp_host.sv ----
// Host controller that programs and checks the flash one-time area.
`timescale 1ns/1ps
module fopc_otp_host (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic progStart,
    input wire fopc_pkg::fopc_req_s progReq,
    input wire logic clearStart,
    input wire logic resetStart,
    input wire logic readStart,
    input wire logic [fopc_pkg::FOPC_ADDR_W-1:0] readAddr,
    input wire logic powerGood,
    input wire logic readyBusyNIn,
    input wire logic [fopc_pkg::FOPC_DATA_W-1:0] flashDataIn,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic resetPowerdownN,
    output logic [fopc_pkg::FOPC_ADDR_W-1:0] flashAddr,
    output logic [fopc_pkg::FOPC_DATA_W-1:0] flashDataOut,
    output logic flashDataOe,
    output logic busy,
    output logic done,
    output logic needRetry,
    output fopc_pkg::fopc_result_s result
);
    import fopc_pkg::*;

    typedef struct packed {
        fopc_state_e state;
        logic [FOPC_CNT_W-1:0] cnt;
        logic start;
        logic isWrite;
        logic [FOPC_ADDR_W-1:0] addr;
        logic [FOPC_DATA_W-1:0] wdata;
        fopc_req_s req;
        logic aborted;
        logic busy;
        logic done;
        logic needRetry;
        fopc_result_s result;
        logic [1:0] pgSync;
        logic [1:0] rbSync;
        logic [FOPC_DATA_W-1:0] dSync1;
        logic [FOPC_DATA_W-1:0] dSync2;
    } fopc_host_s;

    fopc_host_s st_reg;
    fopc_host_s st_next;
    fopc_pins_s pins;
    logic [FOPC_DATA_W-1:0] cycData;
    logic cycDone;

    fopc_bus_cycle u_cycle (
        .mclk(mclk),
        .nrst(nrst),
        .start(st_reg.start),
        .isWrite(st_reg.isWrite),
        .addr(st_reg.addr),
        .wdata(st_reg.wdata),
        .pinData(st_reg.dSync2),
        .pins(pins),
        .rdata(cycData),
        .done(cycDone)
    );

    // ==========================================================
    // Sequencer
    always_comb begin
        st_next = st_reg;
        st_next.start = 1'b0;
        st_next.done = 1'b0;
        st_next.pgSync = {st_reg.pgSync[0], powerGood};
        st_next.rbSync = {st_reg.rbSync[0], readyBusyNIn};
        st_next.dSync1 = flashDataIn;
        st_next.dSync2 = st_reg.dSync1;
        unique case (st_reg.state)
            FOPC_IDLE: begin
                st_next.isWrite = 1'b1;
                st_next.addr = '0;
                // Hold reset while power is not good.
                if (!st_reg.pgSync[1] || resetStart) begin
                    st_next.state = FOPC_RESET;
                    st_next.cnt = FOPC_CNT_W'(FOPC_RESET_CYC);
                    st_next.busy = 1'b1;
                end else if (progStart) begin
                    st_next.req = progReq;
                    st_next.wdata = {8'h00, FOPC_CMD_OTP_SETUP};
                    st_next.start = 1'b1;
                    st_next.state = FOPC_SETUP;
                    st_next.busy = 1'b1;
                end else if (clearStart) begin
                    st_next.wdata = {8'h00, FOPC_CMD_CLEAR_STATUS};
                    st_next.start = 1'b1;
                    st_next.state = FOPC_CLEAR;
                    st_next.busy = 1'b1;
                end else if (readStart) begin
                    st_next.isWrite = 1'b0;
                    st_next.addr = readAddr;
                    st_next.start = 1'b1;
                    st_next.state = FOPC_READ;
                    st_next.busy = 1'b1;
                end
            end
            FOPC_SETUP: if (cycDone) begin
                // Second step carries the data word.
                st_next.addr = st_reg.req.addr;
                st_next.wdata = st_reg.req.data;
                st_next.start = 1'b1;
                st_next.state = FOPC_DATA;
            end
            FOPC_DATA: if (cycDone) begin
                st_next.addr = '0;
                st_next.wdata = {8'h00, FOPC_CMD_READ_STATUS};
                st_next.start = 1'b1;
                st_next.state = FOPC_STAT_CMD;
            end
            FOPC_STAT_CMD: if (cycDone) begin
                st_next.isWrite = 1'b0;
                st_next.start = 1'b1;
                st_next.state = FOPC_POLL;
            end
            FOPC_POLL: if (cycDone) begin
                st_next.result.status = cycData[7:0];
                if (cycData[FOPC_BIT_READY]) begin
                    st_next.needRetry = cycData[FOPC_BIT_SUPPLY_ERR]
                        | cycData[FOPC_BIT_PROTECT_ERR] | cycData[FOPC_BIT_PROG_ERR];
                    st_next.isWrite = 1'b1;
                    st_next.wdata = {8'h00, FOPC_CMD_READ_ARRAY};
                    st_next.start = 1'b1;
                    st_next.state = FOPC_ARRAY;
                end else begin
                    st_next.start = 1'b1;
                end
            end
            FOPC_CLEAR: if (cycDone) begin
                st_next.needRetry = 1'b0;
                st_next.wdata = {8'h00, FOPC_CMD_READ_ARRAY};
                st_next.start = 1'b1;
                st_next.state = FOPC_ARRAY;
            end
            FOPC_ARRAY: if (cycDone) begin
                st_next.state = FOPC_DONE;
            end
            FOPC_READ: if (cycDone) begin
                st_next.result.readData = cycData;
                st_next.state = FOPC_DONE;
            end
            FOPC_RESET: begin
                if (st_reg.cnt != FOPC_CNT_ZERO) begin
                    st_next.cnt = st_reg.cnt - 4'h1;
                end else if (st_reg.pgSync[1]) begin
                    // Busy was low at reset, operation aborted.
                    st_next.aborted = !st_reg.rbSync[1];
                    st_next.needRetry = st_reg.needRetry | !st_reg.rbSync[1];
                    st_next.result.status = 8'h00;
                    st_next.state = FOPC_DONE;
                end
            end
            FOPC_DONE: begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.state = FOPC_IDLE;
            end
            default: st_next.state = FOPC_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{state: FOPC_IDLE, cnt: 4'h0, start: 1'b0, isWrite: 1'b1,
                addr: '0, wdata: '0, req: '0, aborted: 1'b0, busy: 1'b0, done: 1'b0,
                needRetry: 1'b0, result: '0, pgSync: 2'h0, rbSync: 2'h3,
                dSync1: '0, dSync2: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Reset pin register
    logic rstN_reg;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstN_reg <= 1'b0;
        end else begin
            rstN_reg <= (st_next.state != FOPC_RESET);
        end
    end

    assign flashCeN = pins.ceN;
    assign flashWeN = pins.weN;
    assign flashOeN = pins.oeN;
    assign flashAddr = pins.addr;
    assign flashDataOut = pins.dataOut;
    assign flashDataOe = pins.dataOe;
    assign resetPowerdownN = rstN_reg;
    assign busy = st_reg.busy;
    assign done = st_reg.done;
    assign needRetry = st_reg.needRetry;
    assign result = st_reg.result;

    // No strobes while device held in reset.
    a_reset_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        !rstN_reg |-> flashCeN && flashWeN)
        else $error("Strobe active during device reset.");
    // Setup is followed by data write.
    a_setup_data: assert property (@(posedge mclk) disable iff (!nrst)
        (st_reg.state == FOPC_SETUP) && cycDone |=> st_reg.state == FOPC_DATA)
        else $error("Setup not followed by data.");
    a_ready_array: assert property (@(posedge mclk) disable iff (!nrst)
        (st_reg.state == FOPC_POLL) && cycDone && cycData[FOPC_BIT_READY]
        |=> st_reg.state == FOPC_ARRAY)
        else $error("Read-array not issued after ready.");
    a_busy_poll: assert property (@(posedge mclk) disable iff (!nrst)
        (st_reg.state == FOPC_POLL) && cycDone && !cycData[FOPC_BIT_READY]
        |=> st_reg.state == FOPC_POLL && st_reg.start)
        else $error("Polling stopped while busy.");
    a_clear_retry: assert property (@(posedge mclk) disable iff (!nrst)
        (st_reg.state == FOPC_CLEAR) && cycDone |=> !needRetry)
        else $error("Retry flag kept after clear.");
endmodule

// ---- hdl/fopc_pkg.sv ----
// Package with constants and types for the flash program controller.
package fopc_pkg;
    // ==========================================================
    // Commands
    localparam logic [7:0] FOPC_CMD_OTP_SETUP = 8'hC0;
    localparam logic [7:0] FOPC_CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] FOPC_CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] FOPC_CMD_READ_ARRAY = 8'hFF;
    // ==========================================================
    // Status bit positions
    localparam int FOPC_BIT_READY = 7;
    localparam int FOPC_BIT_ERASE_ERR = 5;
    localparam int FOPC_BIT_PROG_ERR = 4;
    localparam int FOPC_BIT_SUPPLY_ERR = 3;
    localparam int FOPC_BIT_PROTECT_ERR = 1;
    // ==========================================================
    // Bus timing in ns, rounded up to cycles of mclk
    localparam int FOPC_CLK_NS = 40;
    localparam int FOPC_STROBE_NS = 100;
    localparam int FOPC_STROBE_CYC = (FOPC_STROBE_NS + FOPC_CLK_NS - 1) / FOPC_CLK_NS;
    localparam int FOPC_RESET_NS = 200;
    localparam int FOPC_RESET_CYC = (FOPC_RESET_NS + FOPC_CLK_NS - 1) / FOPC_CLK_NS;
    localparam int FOPC_CNT_W = 4;
    localparam int FOPC_ADDR_W = 21;
    localparam int FOPC_DATA_W = 16;
    localparam logic [FOPC_CNT_W-1:0] FOPC_CNT_ZERO = 4'h0;
    // ==========================================================
    // Types
    typedef enum logic [9:0] {
        FOPC_IDLE = 10'h001,
        FOPC_SETUP = 10'h002,
        FOPC_DATA = 10'h004,
        FOPC_STAT_CMD = 10'h008,
        FOPC_POLL = 10'h010,
        FOPC_CLEAR = 10'h020,
        FOPC_ARRAY = 10'h040,
        FOPC_RESET = 10'h080,
        FOPC_READ = 10'h100,
        FOPC_DONE = 10'h200
    } fopc_state_e;

    typedef struct packed {
        logic [FOPC_ADDR_W-1:0] addr;
        logic [FOPC_DATA_W-1:0] data;
    } fopc_req_s;

    typedef struct packed {
        logic ceN;
        logic weN;
        logic oeN;
        logic rstN;
        logic dataOe;
        logic [FOPC_ADDR_W-1:0] addr;
        logic [FOPC_DATA_W-1:0] dataOut;
    } fopc_pins_s;

    typedef struct packed {
        logic [7:0] status;
        logic [FOPC_DATA_W-1:0] readData;
    } fopc_result_s;
endpackage

// ---- hdl/fopc_bus_cycle.sv ----
// One write or read cycle on the flash bus with timed strobes.
`timescale 1ns/1ps
module fopc_bus_cycle (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire logic isWrite,
    input wire logic [fopc_pkg::FOPC_ADDR_W-1:0] addr,
    input wire logic [fopc_pkg::FOPC_DATA_W-1:0] wdata,
    input wire logic [fopc_pkg::FOPC_DATA_W-1:0] pinData,
    output fopc_pkg::fopc_pins_s pins,
    output logic [fopc_pkg::FOPC_DATA_W-1:0] rdata,
    output logic done
);
    import fopc_pkg::*;

    typedef struct packed {
        logic busy;
        logic [FOPC_CNT_W-1:0] cnt;
        fopc_pins_s pins;
        logic [FOPC_DATA_W-1:0] rdata;
        logic done;
    } fopc_cyc_s;

    fopc_cyc_s st_reg;
    fopc_cyc_s st_next;

    // ==========================================================
    // Strobe sequencing
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (start && !st_reg.busy) begin
            st_next.busy = 1'b1;
            st_next.cnt = FOPC_CNT_W'(FOPC_STROBE_CYC);
            st_next.pins.addr = addr;
            st_next.pins.dataOut = wdata;
            st_next.pins.dataOe = isWrite;
            st_next.pins.ceN = 1'b0;
            st_next.pins.weN = !isWrite;
            st_next.pins.oeN = isWrite;
        end else if (st_reg.busy) begin
            if (st_reg.cnt != FOPC_CNT_ZERO) begin
                st_next.cnt = st_reg.cnt - 4'h1;
            end else begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.rdata = pinData;
                st_next.pins.ceN = 1'b1;
                st_next.pins.weN = 1'b1;
                st_next.pins.oeN = 1'b1;
                st_next.pins.dataOe = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{busy: 1'b0, cnt: 4'h0,
                pins: '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, rstN: 1'b1, dataOe: 1'b0,
                        addr: '0, dataOut: '0},
                rdata: '0, done: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins = st_reg.pins;
    assign rdata = st_reg.rdata;
    assign done = st_reg.done;

    a_we_under_ce: assert property (@(posedge mclk) disable iff (!nrst)
        !st_reg.pins.weN |-> !st_reg.pins.ceN)
        else $error("Write strobe without chip select.");
endmodule

// ---- test/fopc_flash_model.sv ----
// Behavioural model of the flash device with its status register.
`timescale 1ns/1ps
module fopc_flash_model
    import fopc_pkg::*;
#(
    parameter int PROG_CYC = 20,
    parameter logic [20:0] PROT_BASE = 21'h1F0000
) (
    input wire logic mclk,
    input wire logic ceN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic rstN,
    input wire logic [20:0] addr,
    input wire logic [15:0] dataIn,
    input wire logic supplyBad,
    input wire logic failProg,
    output logic [15:0] dataOut = 16'h5A5A,
    output logic rbOe
);
    logic [15:0] mem [logic [20:0]];
    logic [7:0] status = 8'h80;
    logic statMode = 1'b0;
    logic otpArm = 1'b0;
    logic wrAct = 1'b0;
    logic [20:0] wa;
    logic [15:0] wd;
    int busyCnt = 0;

    assign rbOe = (busyCnt != 0);

    task commit();
        if (otpArm) begin
            otpArm = 1'b0;
            status[7] = 1'b0;
            busyCnt = PROG_CYC;
            if (supplyBad) status[4:3] = 2'b11;
            else if (wa >= PROT_BASE) status[1] = 1'b1;
            else if (failProg) status[4] = 1'b1;
            else mem[wa] = (mem.exists(wa) ? mem[wa] : 16'hFFFF) & wd;
        end else begin
            case (wd[7:0])
                FOPC_CMD_OTP_SETUP: begin
                    otpArm = 1'b1;
                    statMode = 1'b1;
                end
                FOPC_CMD_READ_STATUS: statMode = 1'b1;
                FOPC_CMD_CLEAR_STATUS: status[6:0] = 7'h00;
                FOPC_CMD_READ_ARRAY: statMode = 1'b0;
                default: ;
            endcase
        end
    endtask

    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            status = 8'h80;
            statMode = 1'b0;
            otpArm = 1'b0;
            wrAct = 1'b0;
            busyCnt = 0;
        end else begin
            if (busyCnt > 0) begin
                busyCnt--;
                if (busyCnt == 0) status[7] = 1'b1;
            end
            if (!ceN && !weN) begin
                wrAct = 1'b1;
                wa = addr;
                wd = dataIn;
            end else if (wrAct) begin
                wrAct = 1'b0;
                commit();
            end
        end
    end

    // Released bus toggles so a stale value is never seen.
    always @(mclk) begin
        if (!ceN && !oeN && rstN) begin
            dataOut <= statMode ? {8'h00, status} : (mem.exists(addr) ? mem[addr] : 16'hFFFF);
        end else begin
            dataOut <= ~dataOut;
        end
    end
endmodule

// ---- test/fopc_otp_host_bench.sv ----
// Self-checking bench for the flash program controller.
`timescale 1ns/1ps
module fopc_otp_host_bench;
    import fopc_pkg::*;
    localparam logic [20:0] PROT_BASE = 21'h1F0000;
    logic mclk = 0, nrst = 0, progStart = 0, clearStart = 0, resetStart = 0, readStart = 0;
    logic powerGood = 1, supplyBad = 0, failProg = 0;
    fopc_req_s progReq = '0;
    logic [20:0] readAddr = '0, flashAddr, a;
    logic flashCeN, flashWeN, flashOeN, resetPowerdownN, flashDataOe, busy, done, needRetry, rbOe;
    logic [15:0] flashDataOut, modelOut;
    fopc_result_s result;
    wire logic readyBusyNIn = rbOe ? 1'b0 : 1'b1;
    wire logic [15:0] flashDataIn = flashDataOe ? flashDataOut : modelOut;
    int mismatches = 0, totalChecks = 0;
    logic [7:0] expErr = '0;
    int expMem [int];

    fopc_otp_host u_fopc_otp_host (.mclk(mclk), .nrst(nrst), .progStart(progStart),
        .progReq(progReq), .clearStart(clearStart), .resetStart(resetStart),
        .readStart(readStart), .readAddr(readAddr), .powerGood(powerGood),
        .readyBusyNIn(readyBusyNIn), .flashDataIn(flashDataIn), .flashCeN(flashCeN),
        .flashWeN(flashWeN), .flashOeN(flashOeN), .resetPowerdownN(resetPowerdownN),
        .flashAddr(flashAddr), .flashDataOut(flashDataOut), .flashDataOe(flashDataOe),
        .busy(busy), .done(done), .needRetry(needRetry), .result(result));
    fopc_flash_model #(.PROT_BASE(PROT_BASE)) u_fopc_flash_model (.mclk(mclk),
        .ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN), .rstN(resetPowerdownN),
        .addr(flashAddr), .dataIn(flashDataOut), .supplyBad(supplyBad),
        .failProg(failProg), .dataOut(modelOut), .rbOe(rbOe));

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        totalChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic waitFor(input bit idle);
        int n;
        n = 0;
        while ((idle ? busy !== 1'b0 : done !== 1'b1) && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 4000) mismatches++;
    endtask

    task automatic prog(input logic [20:0] pa, input logic [15:0] d);
        int k;
        k = int'(pa);
        progReq = {pa, d};
        progStart = 1'b1;
        @(negedge mclk);
        progStart = 1'b0;
        waitFor(0);
        if (supplyBad) expErr |= 8'h18;
        else if (pa >= PROT_BASE) expErr |= 8'h02;
        else if (failProg) expErr |= 8'h10;
        else expMem[k] = (expMem.exists(k) ? expMem[k] : 'hFFFF) & int'(d);
        check({16'h0, result.status}, {16'h0, 8'h80 | expErr});
        check({23'h0, needRetry}, {23'h0, expErr != 8'h00});
    endtask

    task automatic rd(input logic [20:0] ra);
        int k;
        k = int'(ra);
        readAddr = ra;
        readStart = 1'b1;
        @(negedge mclk);
        readStart = 1'b0;
        waitFor(0);
        check({8'h0, result.readData}, expMem.exists(k) ? 24'(expMem[k]) : 24'hFFFF);
    endtask

    task automatic pulse(input bit doReset);
        clearStart = !doReset;
        resetStart = doReset;
        @(negedge mclk);
        clearStart = 1'b0;
        resetStart = 1'b0;
        waitFor(0);
        if (!doReset) check({23'h0, needRetry}, 24'h0);
        expErr = '0;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        summarize();
    end

    initial begin
        void'($urandom(82));
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        // The controller pulses the device reset once after its own reset.
        waitFor(0);
        check({23'h0, resetPowerdownN}, 24'h1);
        prog(21'h000100, 16'h1234);
        rd(21'h000100);
        $display("test basic done");
        supplyBad = 1'b1;
        prog(21'h000200, 16'h0F0F);
        supplyBad = 1'b0;
        prog(PROT_BASE + 21'h5, 16'h0000);
        rd(21'h000100);
        $display("test errors done");
        pulse(0);
        failProg = 1'b1;
        prog(21'h000300, 16'hAAAA);
        failProg = 1'b0;
        pulse(0);
        prog(21'h000300, 16'h5555);
        $display("test clear done");
        failProg = 1'b1;
        prog(21'h000301, 16'h1111);
        failProg = 1'b0;
        pulse(1);
        prog(21'h000301, 16'hC3C3);
        rd(21'h000301);
        $display("test reset done");
        failProg = 1'b1;
        prog(21'h000302, 16'h2222);
        failProg = 1'b0;
        powerGood = 1'b0;
        repeat (30) @(negedge mclk);
        powerGood = 1'b1;
        repeat (4) @(negedge mclk);
        waitFor(1);
        expErr = '0;
        prog(21'h000302, 16'h3C3C);
        $display("test power done");
        for (int i = 0; i < 8; i++) begin
            a = 21'($urandom) & 21'h0FFFFF;
            prog(a, 16'($urandom));
            rd(a);
        end
        $display("test random done");
        summarize();
    end
endmodule
